// ---- bus_cycle_pkg.sv ----
// Purpose: Types and shared decoding of the bus machine-cycle sequencer.
// Assumes: Nothing beyond the tool's SystemVerilog support.
// Notes: Constants live in cpu_bus_cycle_map.svh.
`default_nettype none
package bus_cycle_pkg;

  typedef enum logic [3:0] {
    KIND_FETCH,
    KIND_MEM_READ,
    KIND_MEM_WRITE,
    KIND_STACK_READ,
    KIND_STACK_WRITE,
    KIND_INPUT,
    KIND_OUTPUT,
    KIND_INTERRUPT,
    KIND_HALT,
    KIND_HALT_INTERRUPT
  } cycle_kind_type;

  typedef enum logic [2:0] {
    IDLE_STATE,
    FIRST_STATE,
    SECOND_STATE,
    WAIT_STATE,
    THIRD_STATE,
    FOURTH_STATE,
    FIFTH_STATE
  } bus_state_type;

  // Cycles in which data flows into the processor under read-data enable.
  function automatic logic isReadKind(input cycle_kind_type kind);
    isReadKind = (kind == KIND_FETCH) || (kind == KIND_MEM_READ) || (kind == KIND_STACK_READ) ||
                 (kind == KIND_INTERRUPT) || (kind == KIND_INPUT);
  endfunction : isReadKind

  function automatic logic isWriteKind(input cycle_kind_type kind);
    isWriteKind = (kind == KIND_MEM_WRITE) || (kind == KIND_STACK_WRITE) || (kind == KIND_OUTPUT);
  endfunction : isWriteKind

  function automatic logic isOpcodeKind(input cycle_kind_type kind);
    isOpcodeKind = (kind == KIND_FETCH) || (kind == KIND_INTERRUPT) || (kind == KIND_HALT_INTERRUPT);
  endfunction : isOpcodeKind

endpackage : bus_cycle_pkg
`default_nettype wire

// ---- bus_partner_model.sv ----
// Purpose: Memory and peripheral side of the processor bus, facing the sequencer.
// Assumes: One clk period per bus state; waits are counted from the cycle-start strobe.
// Notes: Read data is a fixed function of the address, or a restart opcode in interrupt cycles.
`timescale 1ns/1ps
`include "cpu_bus_cycle_map.svh"
`default_nettype none
module bus_partner_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic syncStrobe,
  input wire logic readDataEnable,
  input wire logic writeStrobe_n,
  input wire logic [`ADDR_WIDTH-1:0] addrOut,
  input wire logic [`DATA_WIDTH-1:0] dataOut,
  input wire logic [2:0] waitReq,
  output logic ready,
  output logic [`DATA_WIDTH-1:0] dataIn,
  output logic [`DATA_WIDTH-1:0] lastWrite
);
  logic [2:0] waitLeft;
  logic [2:0] next_waitLeft;
  logic holdData;
  logic next_holdData;
  logic [`DATA_WIDTH-1:0] lastByte;
  logic [`DATA_WIDTH-1:0] next_lastByte;
  logic [`DATA_WIDTH-1:0] next_lastWrite;
  logic driving;
  logic irqAckSeen;
  logic next_irqAckSeen;
  // Restart opcode jammed onto the bus in interrupt cycles; the value is this model's own choice.
  localparam logic [`DATA_WIDTH-1:0] RESTART_CODE = 8'h3C;

  // Data is held one state past the enable so the third-state sample sees it; once released the
  // lines toggle every state, because a released bus keeps no value worth trusting.
  assign driving = readDataEnable || holdData;
  assign dataIn = driving ? (irqAckSeen ? RESTART_CODE : (addrOut[`DATA_WIDTH-1:0] ^ 8'hA5)) :
                  ~lastByte;
  assign ready = (waitLeft == 3'h0);

  always_comb
  begin
    next_waitLeft = waitLeft;
    if (syncStrobe)
      next_waitLeft = waitReq;
    else if (waitLeft != 3'h0)
      next_waitLeft = waitLeft - 3'h1;
    next_holdData = readDataEnable;
    // The interrupt-acknowledge bit of the status word is latched during the cycle-start strobe, as outside logic would do.
    next_irqAckSeen = syncStrobe ? dataOut[`STATUS_IRQ_ACK_BIT] : irqAckSeen;
    next_lastByte = dataIn;
    next_lastWrite = writeStrobe_n ? lastWrite : dataOut;
    if (sys_rst)
    begin
      next_waitLeft = 3'h0;
      next_holdData = 1'h0;
      next_irqAckSeen = 1'h0;
      next_lastByte = 8'h00;
      next_lastWrite = 8'h00;
    end
  end

  always_ff @(posedge clk)
  begin
    waitLeft <= next_waitLeft;
    holdData <= next_holdData;
    irqAckSeen <= next_irqAckSeen;
    lastByte <= next_lastByte;
    lastWrite <= next_lastWrite;
  end
endmodule : bus_partner_model
`default_nettype wire

// ---- cpu_bus_cycle_map.svh ----
// Purpose: Constants of the bus machine-cycle sequencer: status bit positions, widths, reset values, timing.
// Assumes: Included by bare name; definitions only.
// Notes: One clock period of clk stands for one bus state.
`ifndef CPU_BUS_CYCLE_MAP_SVH
`define CPU_BUS_CYCLE_MAP_SVH

`define ADDR_WIDTH 16
`define DATA_WIDTH 8
`define EXTRA_WIDTH 2

`define STATUS_IRQ_ACK_BIT 0
`define STATUS_WRITE_N_BIT 1
`define STATUS_STACK_BIT 2
`define STATUS_HALT_ACK_BIT 3
`define STATUS_OUTPUT_BIT 4
`define STATUS_OPCODE_FETCH_BIT 5
`define STATUS_INPUT_BIT 6
`define STATUS_MEM_READ_BIT 7

`define ADDR_RESET 16'h0000
`define DATA_RESET 8'h00
`define EXTRA_NONE 2'h0
`define EXTRA_ONE 2'h1

`define CLK_PERIOD_NS 25
`define STATE_TIME_NS 25
`define STATE_CYCLES ((`STATE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- cpu_bus_cycle_sequencer.sv ----
// Purpose: Steps a processor bus through the states of each machine cycle and drives its strobes.
// Assumes: One clk period is one bus state; phase-two events are aligned to the state's own edge.
// Notes: Cycles are fed through cycleValid/cycleTaken; with none pending the bus rests in idle.
`timescale 1ns/1ps
`include "cpu_bus_cycle_map.svh"
`default_nettype none
module cpu_bus_cycle_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cycleValid,
  input wire bus_cycle_pkg::cycle_kind_type cycleKind,
  input wire logic [`ADDR_WIDTH-1:0] cycleAddr,
  input wire logic [`DATA_WIDTH-1:0] cycleData,
  input wire logic [`EXTRA_WIDTH-1:0] cycleExtraStates,
  input wire logic ready,
  input wire logic [`DATA_WIDTH-1:0] dataIn,
  output logic cycleTaken,
  output logic syncStrobe,
  output logic waitAck,
  output logic readDataEnable,
  output logic writeStrobe_n,
  output logic [`ADDR_WIDTH-1:0] addrOut,
  output logic [`DATA_WIDTH-1:0] dataOut,
  output logic dataOutEnable_n,
  output logic [`DATA_WIDTH-1:0] capturedData,
  output logic captureValid,
  output logic capturedOpcode,
  output bus_cycle_pkg::bus_state_type busState
);

  bus_cycle_pkg::cycle_kind_type curKind;
  logic [`DATA_WIDTH-1:0] curData;
  logic [`EXTRA_WIDTH-1:0] curExtra;
  logic [`DATA_WIDTH-1:0] newStatus;

  bus_cycle_pkg::bus_state_type next_busState;
  bus_cycle_pkg::cycle_kind_type next_curKind;
  logic [`DATA_WIDTH-1:0] next_curData;
  logic [`EXTRA_WIDTH-1:0] next_curExtra;
  logic next_cycleTaken;
  logic next_syncStrobe;
  logic next_waitAck;
  logic next_readDataEnable;
  logic next_writeStrobe_n;
  logic [`ADDR_WIDTH-1:0] next_addrOut;
  logic [`DATA_WIDTH-1:0] next_dataOut;
  logic next_dataOutEnable_n;
  logic [`DATA_WIDTH-1:0] next_capturedData;
  logic next_captureValid;
  logic next_capturedOpcode;
  bus_cycle_pkg::cycle_kind_type effKind;

  cycle_status_encoder statusEncoder (
    .kind(cycleKind),
    .statusWord(newStatus)
  );

  // State sequence and descriptor latching.
  always_comb
  begin
    next_busState = busState;
    next_curKind = curKind;
    next_curData = curData;
    next_curExtra = curExtra;
    next_cycleTaken = 1'h0;
    case (busState)
      bus_cycle_pkg::IDLE_STATE:
      begin
        if (cycleValid)
        begin
          next_busState = bus_cycle_pkg::FIRST_STATE;
        end
      end
      bus_cycle_pkg::FIRST_STATE:
      begin
        next_busState = bus_cycle_pkg::SECOND_STATE;
      end
      bus_cycle_pkg::SECOND_STATE:
      begin
        // Ready is looked at only here and in the wait state, so a wait always lasts whole states.
        next_busState = ready ? bus_cycle_pkg::THIRD_STATE : bus_cycle_pkg::WAIT_STATE;
      end
      bus_cycle_pkg::WAIT_STATE:
      begin
        next_busState = ready ? bus_cycle_pkg::THIRD_STATE : bus_cycle_pkg::WAIT_STATE;
      end
      bus_cycle_pkg::THIRD_STATE:
      begin
        if (curExtra != `EXTRA_NONE)
        begin
          next_busState = bus_cycle_pkg::FOURTH_STATE;
        end
        else
        begin
          next_busState = cycleValid ? bus_cycle_pkg::FIRST_STATE : bus_cycle_pkg::IDLE_STATE;
        end
      end
      bus_cycle_pkg::FOURTH_STATE:
      begin
        if (curExtra != `EXTRA_ONE)
        begin
          next_busState = bus_cycle_pkg::FIFTH_STATE;
        end
        else
        begin
          next_busState = cycleValid ? bus_cycle_pkg::FIRST_STATE : bus_cycle_pkg::IDLE_STATE;
        end
      end
      bus_cycle_pkg::FIFTH_STATE:
      begin
        next_busState = cycleValid ? bus_cycle_pkg::FIRST_STATE : bus_cycle_pkg::IDLE_STATE;
      end
      default:
      begin
        next_busState = bus_cycle_pkg::IDLE_STATE;
      end
    endcase
    if (next_busState == bus_cycle_pkg::FIRST_STATE)
    begin
      next_curKind = cycleKind;
      next_curData = cycleData;
      // More than two internal states are not possible; the excess is dropped.
      next_curExtra = (cycleExtraStates > 2'h2) ? 2'h2 : cycleExtraStates;
      next_cycleTaken = 1'h1;
    end
  end

  // Bus outputs, computed for the state being entered so that each strobe flop matches its state; capture flops load as the third state ends.
  always_comb
  begin
    effKind = next_curKind;
    next_syncStrobe = (next_busState == bus_cycle_pkg::FIRST_STATE);
    next_waitAck = (next_busState == bus_cycle_pkg::WAIT_STATE);
    next_readDataEnable = bus_cycle_pkg::isReadKind(effKind) &&
                          ((next_busState == bus_cycle_pkg::SECOND_STATE) ||
                           (next_busState == bus_cycle_pkg::WAIT_STATE));
    next_writeStrobe_n = !(bus_cycle_pkg::isWriteKind(effKind) &&
                           ((next_busState == bus_cycle_pkg::WAIT_STATE) ||
                            (next_busState == bus_cycle_pkg::THIRD_STATE)));
    next_addrOut = addrOut;
    next_dataOut = dataOut;
    next_dataOutEnable_n = dataOutEnable_n;
    next_capturedData = capturedData;
    next_captureValid = 1'h0;
    next_capturedOpcode = capturedOpcode;
    if (next_busState == bus_cycle_pkg::FIRST_STATE)
    begin
      next_addrOut = cycleAddr;
      next_dataOut = newStatus;
      next_dataOutEnable_n = 1'h0;
    end
    else if (next_busState == bus_cycle_pkg::SECOND_STATE)
    begin
      if (bus_cycle_pkg::isWriteKind(effKind))
      begin
        // Write data stays on the lines until the next status word replaces it.
        next_dataOut = curData;
        next_dataOutEnable_n = 1'h0;
      end
      else
      begin
        next_dataOutEnable_n = 1'h1;
      end
    end
    if ((busState == bus_cycle_pkg::THIRD_STATE) && bus_cycle_pkg::isReadKind(curKind))
    begin
      next_capturedData = dataIn;
      next_captureValid = 1'h1;
      next_capturedOpcode = bus_cycle_pkg::isOpcodeKind(curKind);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busState <= bus_cycle_pkg::IDLE_STATE;
      curKind <= bus_cycle_pkg::KIND_FETCH;
      curData <= `DATA_RESET;
      curExtra <= `EXTRA_NONE;
      cycleTaken <= 1'h0;
      syncStrobe <= 1'h0;
      waitAck <= 1'h0;
      readDataEnable <= 1'h0;
      writeStrobe_n <= 1'h1;
      addrOut <= `ADDR_RESET;
      dataOut <= `DATA_RESET;
      dataOutEnable_n <= 1'h1;
      capturedData <= `DATA_RESET;
      captureValid <= 1'h0;
      capturedOpcode <= 1'h0;
    end
    else
    begin
      busState <= next_busState;
      curKind <= next_curKind;
      curData <= next_curData;
      curExtra <= next_curExtra;
      cycleTaken <= next_cycleTaken;
      syncStrobe <= next_syncStrobe;
      waitAck <= next_waitAck;
      readDataEnable <= next_readDataEnable;
      writeStrobe_n <= next_writeStrobe_n;
      addrOut <= next_addrOut;
      dataOut <= next_dataOut;
      dataOutEnable_n <= next_dataOutEnable_n;
      capturedData <= next_capturedData;
      captureValid <= next_captureValid;
      capturedOpcode <= next_capturedOpcode;
    end
  end

  // Checks.
  logic [`DATA_WIDTH-1:0] expectStatus;

  cycle_status_encoder checkEncoder (
    .kind(curKind),
    .statusWord(expectStatus)
  );

  a_state_advance: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::FIRST_STATE |=> busState == bus_cycle_pkg::SECOND_STATE)
    else $error("First state not followed by second state.");

  a_sync_first_only: assert property (@(posedge clk) disable iff (sys_rst)
    syncStrobe == (busState == bus_cycle_pkg::FIRST_STATE))
    else $error("Cycle-start strobe outside the first state.");

  a_status_on_bus: assert property (@(posedge clk) disable iff (sys_rst)
    syncStrobe |-> !dataOutEnable_n && dataOut == expectStatus)
    else $error("Status word missing while cycle-start strobe is high.");

  a_address_held: assert property (@(posedge clk) disable iff (sys_rst)
    busState inside {bus_cycle_pkg::SECOND_STATE, bus_cycle_pkg::WAIT_STATE, bus_cycle_pkg::THIRD_STATE}
    |-> $stable(addrOut))
    else $error("Address changed before the third state ended.");

  a_wait_entry: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::SECOND_STATE && !ready |=> busState == bus_cycle_pkg::WAIT_STATE && waitAck)
    else $error("Ready low in second state did not enter a wait with acknowledge.");

  a_wait_ack_level: assert property (@(posedge clk) disable iff (sys_rst)
    waitAck == (busState == bus_cycle_pkg::WAIT_STATE))
    else $error("Wait acknowledge does not match the wait state.");

  a_wait_exit: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::WAIT_STATE |=>
    busState == ($past(ready) ? bus_cycle_pkg::THIRD_STATE : bus_cycle_pkg::WAIT_STATE))
    else $error("Wait state left or kept against ready.");

  a_read_release: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::SECOND_STATE && bus_cycle_pkg::isReadKind(curKind) |-> dataOutEnable_n)
    else $error("Data lines still driven in a read-type cycle.");

  a_read_enable_span: assert property (@(posedge clk) disable iff (sys_rst)
    readDataEnable == (bus_cycle_pkg::isReadKind(curKind) &&
    busState inside {bus_cycle_pkg::SECOND_STATE, bus_cycle_pkg::WAIT_STATE}))
    else $error("Read-data enable outside the second and wait states of a read.");

  a_output_held: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::WAIT_STATE && bus_cycle_pkg::isWriteKind(curKind)
    |-> !dataOutEnable_n && dataOut == curData && $stable(dataOut))
    else $error("Output data not stable during a wait.");

  a_write_strobe: assert property (@(posedge clk) disable iff (sys_rst)
    !writeStrobe_n == (bus_cycle_pkg::isWriteKind(curKind) &&
    busState inside {bus_cycle_pkg::WAIT_STATE, bus_cycle_pkg::THIRD_STATE}))
    else $error("Write strobe low outside the write window.");

  a_tail_states: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::THIRD_STATE |=> busState inside
    {bus_cycle_pkg::FOURTH_STATE, bus_cycle_pkg::FIRST_STATE, bus_cycle_pkg::IDLE_STATE})
    else $error("Third state followed by an illegal state.");

  a_fetch_flag: assert property (@(posedge clk) disable iff (sys_rst)
    syncStrobe && dataOut[`STATUS_OPCODE_FETCH_BIT] |-> bus_cycle_pkg::isOpcodeKind(curKind))
    else $error("Opcode fetch flag set outside a fetch cycle.");

  a_capture_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::THIRD_STATE && bus_cycle_pkg::isReadKind(curKind)
    |=> captureValid && capturedData == $past(dataIn))
    else $error("Read data not captured at the third state.");

  c_wait_cycle: cover property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::WAIT_STATE ##1 busState == bus_cycle_pkg::WAIT_STATE ##1
    busState == bus_cycle_pkg::THIRD_STATE);

  c_five_state: cover property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::FIFTH_STATE ##1 busState == bus_cycle_pkg::FIRST_STATE);

  c_output_wait: cover property (@(posedge clk) disable iff (sys_rst)
    busState == bus_cycle_pkg::WAIT_STATE && curKind == bus_cycle_pkg::KIND_OUTPUT);

endmodule : cpu_bus_cycle_sequencer
`default_nettype wire

// ---- cycle_status_encoder.sv ----
// Purpose: Builds the eight-bit status word for a machine-cycle kind.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Bits are positive-true except the write flag, which is active low.
`timescale 1ns/1ps
`include "cpu_bus_cycle_map.svh"
`default_nettype none
module cycle_status_encoder (
  input wire bus_cycle_pkg::cycle_kind_type kind,
  output logic [`DATA_WIDTH-1:0] statusWord
);

  always_comb
  begin
    statusWord = `DATA_RESET;
    statusWord[`STATUS_IRQ_ACK_BIT] = (kind == bus_cycle_pkg::KIND_INTERRUPT) ||
                                      (kind == bus_cycle_pkg::KIND_HALT_INTERRUPT);
    statusWord[`STATUS_WRITE_N_BIT] = !bus_cycle_pkg::isWriteKind(kind);
    statusWord[`STATUS_STACK_BIT] = (kind == bus_cycle_pkg::KIND_STACK_READ) ||
                                    (kind == bus_cycle_pkg::KIND_STACK_WRITE);
    statusWord[`STATUS_HALT_ACK_BIT] = (kind == bus_cycle_pkg::KIND_HALT) ||
                                       (kind == bus_cycle_pkg::KIND_HALT_INTERRUPT);
    statusWord[`STATUS_OUTPUT_BIT] = (kind == bus_cycle_pkg::KIND_OUTPUT);
    statusWord[`STATUS_OPCODE_FETCH_BIT] = bus_cycle_pkg::isOpcodeKind(kind);
    statusWord[`STATUS_INPUT_BIT] = (kind == bus_cycle_pkg::KIND_INPUT);
    statusWord[`STATUS_MEM_READ_BIT] = (kind == bus_cycle_pkg::KIND_FETCH) ||
                                       (kind == bus_cycle_pkg::KIND_MEM_READ) ||
                                       (kind == bus_cycle_pkg::KIND_STACK_READ) ||
                                       (kind == bus_cycle_pkg::KIND_HALT);
  end

endmodule : cycle_status_encoder
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench of the bus machine-cycle sequencer.
// Assumes: The partner model answers reads and counts the wait states it asks for.
// Notes: Halt kinds skip the state-count check; their status bits are compared under a mask.
`timescale 1ns/1ps
`include "cpu_bus_cycle_map.svh"
`default_nettype none
`define CHK_EQ(a, b) begin cmpCount++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  typedef struct packed {
    bus_cycle_pkg::cycle_kind_type kind;
    logic [15:0] addr;
    logic [7:0] data;
    logic [1:0] extra;
    logic [2:0] waits;
    logic rd;
    logic wr;
    logic [7:0] status;
    logic [7:0] mask;
  } row_type;
  // Halt rows mask bit seven, whose meaning in a halt cycle is left open.
  localparam row_type ROWS [10] = '{
    '{bus_cycle_pkg::KIND_FETCH, 16'h1234, 8'h00, 2'h1, 3'h0, 1'h1, 1'h0, 8'hA2, 8'hFF},
    '{bus_cycle_pkg::KIND_MEM_READ, 16'hABCD, 8'h00, 2'h0, 3'h2, 1'h1, 1'h0, 8'h82, 8'hFF},
    '{bus_cycle_pkg::KIND_MEM_WRITE, 16'h0F0F, 8'h5A, 2'h0, 3'h0, 1'h0, 1'h1, 8'h00, 8'hFF},
    '{bus_cycle_pkg::KIND_STACK_READ, 16'hFFFE, 8'h00, 2'h2, 3'h1, 1'h1, 1'h0, 8'h86, 8'hFF},
    '{bus_cycle_pkg::KIND_STACK_WRITE, 16'hFFFC, 8'hC3, 2'h3, 3'h0, 1'h0, 1'h1, 8'h04, 8'hFF},
    '{bus_cycle_pkg::KIND_INPUT, 16'h0042, 8'h00, 2'h0, 3'h1, 1'h1, 1'h0, 8'h42, 8'hFF},
    '{bus_cycle_pkg::KIND_OUTPUT, 16'h0081, 8'h96, 2'h0, 3'h3, 1'h0, 1'h1, 8'h10, 8'hFF},
    '{bus_cycle_pkg::KIND_INTERRUPT, 16'h0100, 8'h00, 2'h0, 3'h0, 1'h1, 1'h0, 8'h23, 8'hFF},
    '{bus_cycle_pkg::KIND_HALT, 16'h0200, 8'h00, 2'h0, 3'h0, 1'h0, 1'h0, 8'h0A, 8'h7F},
    '{bus_cycle_pkg::KIND_HALT_INTERRUPT, 16'h0300, 8'h00, 2'h0, 3'h0, 1'h0, 1'h0, 8'h2B, 8'h7F}};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cycleValid = 1'h0;
  bus_cycle_pkg::cycle_kind_type cycleKind = bus_cycle_pkg::KIND_FETCH;
  logic [`ADDR_WIDTH-1:0] cycleAddr = 16'h0000;
  logic [`DATA_WIDTH-1:0] cycleData = 8'h00;
  logic [`EXTRA_WIDTH-1:0] cycleExtraStates = 2'h0;
  logic [2:0] waitReq = 3'h0;
  logic ready, cycleTaken, syncStrobe, waitAck, readDataEnable, writeStrobe_n, dataOutEnable_n;
  logic captureValid, capturedOpcode;
  logic [`DATA_WIDTH-1:0] dataIn, dataOut, capturedData, lastWrite;
  logic [`ADDR_WIDTH-1:0] addrOut;
  bus_cycle_pkg::bus_state_type busState;
  int mismatches = 0;
  int cmpCount = 0;

  cpu_bus_cycle_sequencer uut (.clk, .sys_rst, .cycleValid, .cycleKind, .cycleAddr, .cycleData,
    .cycleExtraStates, .ready, .dataIn, .cycleTaken, .syncStrobe, .waitAck, .readDataEnable,
    .writeStrobe_n, .addrOut, .dataOut, .dataOutEnable_n, .capturedData, .captureValid,
    .capturedOpcode, .busState);
  bus_partner_model mem (.clk, .sys_rst, .syncStrobe, .readDataEnable, .writeStrobe_n, .addrOut,
    .dataOut, .waitReq, .ready, .dataIn, .lastWrite);

  initial
  begin
    forever #(`CLK_PERIOD_NS / 2.0) clk = ~clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic setReq(input row_type r);
    cycleValid = 1'h1;
    cycleKind = r.kind;
    cycleAddr = r.addr;
    cycleData = r.data;
    cycleExtraStates = r.extra;
    waitReq = r.waits;
  endtask : setReq

  // Returns one nanosecond after the edge that starts the first state, so n counts states.
  task automatic waitTake(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (cycleTaken !== 1'h1 && n < 20);
    `CHK_EQ(syncStrobe, 1'h1)
  endtask : waitTake

  task automatic idleCheck();
    `CHK_EQ(busState, bus_cycle_pkg::IDLE_STATE)
    `CHK_EQ({syncStrobe, waitAck, writeStrobe_n, dataOutEnable_n}, 4'h3)
  endtask : idleCheck

  task automatic runRow(input row_type r);
    int n;
    int st = 1;
    int syncC = 0;
    int waitC = 0;
    int rdeC = 0;
    int wrC = 0;
    int bad = 0;
    int capC = 0;
    logic [7:0] capV = 8'h00;
    bit done;
    @(posedge clk);
    #1;
    setReq(r);
    waitTake(n);
    `CHK_EQ(dataOut & r.mask, r.status & r.mask)
    `CHK_EQ(dataOutEnable_n, 1'h0)
    `CHK_EQ(addrOut, r.addr)
    cycleValid = 1'h0;
    do
    begin
      @(posedge clk);
      #1;
      if (captureValid === 1'h1)
      begin
        capC++;
        capV = capturedData;
      end
      done = (busState === bus_cycle_pkg::FIRST_STATE) || (busState === bus_cycle_pkg::IDLE_STATE) || st > 12;
      if (!done)
      begin
        st++;
        syncC += (syncStrobe !== 1'h0);
        waitC += (waitAck === 1'h1);
        rdeC += (readDataEnable === 1'h1);
        wrC += (writeStrobe_n === 1'h0);
        bad += (addrOut !== r.addr) || (r.wr && dataOut !== r.data) ||
               (st == 2 && r.mask == 8'hFF && dataOutEnable_n !== !r.wr);
      end
    end
    while (!done);
    `CHK_EQ(syncC, 0)
    `CHK_EQ(bad, 0)
    `CHK_EQ(waitC, int'(r.waits))
    `CHK_EQ(rdeC, r.rd ? 1 + r.waits : 0)
    `CHK_EQ(wrC, r.wr ? 1 + r.waits : 0)
    if (r.mask == 8'hFF)
      `CHK_EQ(st, 3 + r.waits + (r.extra > 2'h2 ? 2 : r.extra))
    if (r.rd)
    begin
      `CHK_EQ(capC, 1)
      `CHK_EQ(capV, r.status[0] ? 8'h3C : r.addr[7:0] ^ 8'hA5)
      `CHK_EQ(capturedOpcode, r.status[5])
    end
    if (r.wr)
      `CHK_EQ(lastWrite, r.data)
  endtask : runRow

  initial
  begin
    #(`CLK_PERIOD_NS * 4000);
    mismatches++;
    results();
  end

  initial
  begin
    int n;
    row_type longOut;
    repeat (8) @(posedge clk);
    #1;
    idleCheck();
    sys_rst = 1'h0;
    $display("test reset done");
    foreach (ROWS[i])
    begin
      runRow(ROWS[i]);
      $display("test row %0d done", i);
    end
    // Descriptor kept valid across the take: the next cycle follows the fourth state directly.
    setReq(ROWS[0]);
    waitTake(n);
    setReq(ROWS[2]);
    waitTake(n);
    `CHK_EQ(n, 4)
    `CHK_EQ(dataOut, 8'h00)
    cycleValid = 1'h0;
    runRow(ROWS[3]);
    $display("test back to back done");
    // Reset in the middle of a long output wait must drop every strobe.
    longOut = ROWS[6];
    longOut.waits = 3'h7;
    setReq(longOut);
    waitTake(n);
    cycleValid = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK_EQ({waitAck, writeStrobe_n, dataOut}, {2'h2, 8'h96})
    sys_rst = 1'h1;
    @(posedge clk);
    #1;
    idleCheck();
    sys_rst = 1'h0;
    runRow(ROWS[1]);
    $display("test mid reset done");
    results();
  end
endmodule : tb
`default_nettype wire
